// ===== rtl/cmp_params.svh
// constants of the can output message packer
`ifndef CMP_PARAMS_SVH
`define CMP_PARAMS_SVH
// ********************************************
// timing
// ********************************************
`define CMP_CLK_HZ     20000000
`define CMP_TICK_MS    1
// ********************************************
// sizes
// ********************************************
`define CMP_NMSG       2
`define CMP_NSLOT      5
`define CMP_NSRC       8
`define CMP_RATE_MAX   14'h2710
// ********************************************
// register offsets, per message block
// ********************************************
`define CMP_MSG_STRIDE 10'h100
`define CMP_OFS_CTRL   8'h00
`define CMP_OFS_PGN    8'h04
`define CMP_OFS_RATE   8'h08
`define CMP_OFS_STAT   8'h0c
`define CMP_OFS_SLOT   8'h20
`define CMP_OFS_SLEND  8'hc0
`define CMP_SLR_CFG    3'h0
`define CMP_SLR_RES    3'h1
`define CMP_SLR_OFF    3'h2
`define CMP_SLR_MAX    3'h3
`define CMP_SLR_MIN    3'h4
// ********************************************
// reset values and frame fields
// ********************************************
`define CMP_PGN1_RST   18'h0ff01
`define CMP_PGN2_RST   18'h0ff02
`define CMP_SLOT_RST   16'h11f0
`define CMP_RES_RST    32'h00000001
`define CMP_MAX_RST    32'h00000001
`define CMP_PRIO       3'h6
`define CMP_PDU2_PF    8'hf0
`define CMP_GLOBAL_DA  8'hff
`define CMP_UNUSED     64'hffffffffffffffff
`endif

// ===== rtl/cmp_pkg.sv
// types of the can output message packer
package cmp_pkg;
  typedef enum logic [2:0] {
    CMP_T_UNDEF = 3'h0, CMP_T_BIT1 = 3'h1, CMP_T_BIT2 = 3'h2, CMP_T_BIT4 = 3'h3,
    CMP_T_BYTE1 = 3'h4, CMP_T_BYTE2 = 3'h5, CMP_T_BYTE4 = 3'h6
  } cmp_kind_t;
  typedef enum logic [1:0] {
    CMP_S_VALID = 2'h0, CMP_S_SPECIAL = 2'h1, CMP_S_ERROR = 2'h2, CMP_S_NA = 2'h3
  } cmp_sstate_t;
  typedef struct packed {
    cmp_sstate_t        state;
    logic [23:0]        code;
    logic signed [31:0] value;
  } cmp_sig_t;
  typedef struct packed {
    logic [28:0] id;
    logic [63:0] data;
  } cmp_frame_t;
  typedef struct packed {
    logic [3:0] bitpos;
    logic [3:0] bytepos;
    logic [3:0] src;
    logic       inv;
    cmp_kind_t  kind;
  } cmp_slot_t;
  typedef enum logic [1:0] {
    CMP_IDLE = 2'b00, CMP_PACK = 2'b01, CMP_SEND = 2'b11
  } cmp_fsm_t;
endpackage

// ===== rtl/cmp_top.sv
// can output message packer with wishbone setup registers
// Function
// - two independent output message instances, each one single can data frame.
// - each message is sent periodically or on request.
// - up to five signal slots per message, each optionally inverted.
// - no destination; pdu1 pgns go to the global address.
// - enable bit defaults off; a disabled message starts no new frame, but one already started still finishes.
// - rate 0..10000 ms, default 0; 0 means request only.
// - slot type undefined, 1/2/4-bit discrete or 1/2/4-byte continuous.
// - slot source is any logical output or unconnected, the default.
// - inversion option, default off, inverts the value before encoding.
// - byte position 1..8, default 1; lsb byte for continuous types.
// - discrete bit position 1..8, default 1, lowest signal bit in byte.
// - resolution default 1; a zero resolution is refused.
// - offset default 0, subtracted before scaling continuous values.
// - max default 1, min default 0; max must exceed min.
// - special and error codes sent as offsets in the reserved range.
`timescale 1ns/1ps
`include "cmp_params.svh"
module cmp_top #(
  parameter int unsigned MS_CYCLES = `CMP_CLK_HZ / 1000 * `CMP_TICK_MS
) (
  // clock and reset
  input  wire  logic                              CORE_CLK,
  input  wire  logic                              ARST_N,
  // wishbone slave
  input  wire  logic                              WB_CYC_I,
  input  wire  logic                              WB_STB_I,
  input  wire  logic                              WB_WE_I,
  input  wire  logic [9:0]                        WB_ADR_I,
  input  wire  logic [3:0]                        WB_SEL_I,
  input  wire  logic [31:0]                       WB_DAT_I,
  output logic       [31:0]                       WB_DAT_O,
  output logic                                    WB_ACK_O,
  // logical outputs of the function blocks
  input  wire  cmp_pkg::cmp_sig_t [`CMP_NSRC-1:0] SIG_IN,
  input  wire  logic [`CMP_NMSG-1:0]              REQ,
  input  wire  logic [7:0]                        SRC_ADDR,
  // frame towards the can controller
  output logic                                    TX_VALID,
  input  wire  logic                              TX_READY,
  output cmp_pkg::cmp_frame_t                     TX_FRAME
);
  import cmp_pkg::*;

  // ********************************************
  // setup storage
  // ********************************************
  localparam int NS = `CMP_NMSG * `CMP_NSLOT;
  logic [`CMP_NMSG-1:0] en;
  logic [17:0]          pgn [`CMP_NMSG];
  logic [13:0]          rate [`CMP_NMSG];
  logic [15:0]          sent [`CMP_NMSG];
  cmp_slot_t            slot [NS];
  logic signed [31:0]   res [NS];
  logic signed [31:0]   ofs [NS];
  logic signed [31:0]   smax [NS];
  logic signed [31:0]   smin [NS];
  logic [`CMP_NMSG-1:0] pend;
  cmp_fsm_t             state;
  logic                 cur_m;
  logic [2:0]           sc;

  // ********************************************
  // wishbone decode
  // ********************************************
  logic        req_on;
  logic        wr;
  logic        am;
  logic [7:0]  loc;
  logic [7:0]  sl_ofs;
  logic [2:0]  sl_s;
  logic [3:0]  wi;
  logic [31:0] cur;
  logic [31:0] bmask;
  logic [31:0] merged;
  logic        is_slot;
  cmp_slot_t   ncfg;

  assign req_on  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr      = req_on & WB_WE_I;
  assign am      = WB_ADR_I[8];
  assign loc     = WB_ADR_I[7:0];
  assign sl_ofs  = loc - `CMP_OFS_SLOT;
  assign sl_s    = sl_ofs[7:5];
  assign wi      = am ? 4'(`CMP_NSLOT) + {1'b0, sl_s} : {1'b0, sl_s};
  assign is_slot = (loc >= `CMP_OFS_SLOT) && (loc < `CMP_OFS_SLEND) && (WB_ADR_I[9] == 1'b0);
  assign bmask   = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign merged  = (cur & ~bmask) | (WB_DAT_I & bmask);
  assign ncfg    = cmp_slot_t'(merged[15:0]);

  // current value at the address, for reads and byte-lane merging
  always_comb begin
    cur = 32'h0;
    if (WB_ADR_I[9]) begin
      cur = 32'h0;
    end else if (loc == `CMP_OFS_CTRL) begin
      cur = {31'h0, en[am]};
    end else if (loc == `CMP_OFS_PGN) begin
      cur = {14'h0, pgn[am]};
    end else if (loc == `CMP_OFS_RATE) begin
      cur = {18'h0, rate[am]};
    end else if (loc == `CMP_OFS_STAT) begin
      cur = {14'h0, (state != CMP_IDLE) && (cur_m == am), pend[am], sent[am]};
    end else if (is_slot && sl_ofs[1:0] == 2'h0) begin
      if (sl_ofs[4:2] == `CMP_SLR_CFG) begin
        cur = {16'h0, slot[wi]};
      end else if (sl_ofs[4:2] == `CMP_SLR_RES) begin
        cur = res[wi];
      end else if (sl_ofs[4:2] == `CMP_SLR_OFF) begin
        cur = ofs[wi];
      end else if (sl_ofs[4:2] == `CMP_SLR_MAX) begin
        cur = smax[wi];
      end else if (sl_ofs[4:2] == `CMP_SLR_MIN) begin
        cur = smin[wi];
      end
    end
  end

  // ack one cycle after the request; unmapped reads answer zero
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= req_on;
      if (req_on) begin
        WB_DAT_O <= cur;
      end
    end
  end

  // message setup registers
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      en      <= '0;
      pgn[0]  <= `CMP_PGN1_RST;
      pgn[1]  <= `CMP_PGN2_RST;
      rate[0] <= 14'h0;
      rate[1] <= 14'h0;
    end else if (wr && !WB_ADR_I[9]) begin
      if (loc == `CMP_OFS_CTRL) begin
        en[am] <= merged[0];
      end else if (loc == `CMP_OFS_PGN) begin
        pgn[am] <= merged[17:0];
      end else if (loc == `CMP_OFS_RATE) begin
        // out of range rates are refused and the old rate stays
        if (merged[31:0] <= {18'h0, `CMP_RATE_MAX}) begin
          rate[am] <= merged[13:0];
        end
      end
    end
  end

  // slot setup registers; invalid values are refused silently
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < NS; i++) begin
        slot[i] <= cmp_slot_t'(`CMP_SLOT_RST);
        res[i]  <= `CMP_RES_RST;
        ofs[i]  <= 32'h0;
        smax[i] <= `CMP_MAX_RST;
        smin[i] <= 32'h0;
      end
    end else if (wr && is_slot && sl_ofs[1:0] == 2'h0) begin
      if (sl_ofs[4:2] == `CMP_SLR_CFG) begin
        if (ncfg.kind <= CMP_T_BYTE4 && ncfg.bytepos >= 4'h1 && ncfg.bytepos <= 4'h8 &&
            ncfg.bitpos >= 4'h1 && ncfg.bitpos <= 4'h8) begin
          slot[wi] <= ncfg;
        end
      end else if (sl_ofs[4:2] == `CMP_SLR_RES) begin
        if (merged != 32'h0) begin
          res[wi] <= merged;
        end
      end else if (sl_ofs[4:2] == `CMP_SLR_OFF) begin
        ofs[wi] <= merged;
      end else if (sl_ofs[4:2] == `CMP_SLR_MAX) begin
        if ($signed(merged) > smin[wi]) begin
          smax[wi] <= merged;
        end
      end else if (sl_ofs[4:2] == `CMP_SLR_MIN) begin
        if ($signed(merged) < smax[wi]) begin
          smin[wi] <= merged;
        end
      end
    end
  end

  // ********************************************
  // millisecond tick and periodic timers
  // ********************************************
  logic [14:0]          ms_cnt;
  logic                 tick;
  logic [13:0]          rcnt [`CMP_NMSG];
  logic [`CMP_NMSG-1:0] per_hit;
  logic [`CMP_NMSG-1:0] start;
  logic [`CMP_NMSG-1:0] next_pend;

  assign tick = (ms_cnt == 15'(MS_CYCLES - 1));

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ms_cnt <= 15'h0;
    end else begin
      ms_cnt <= tick ? 15'h0 : ms_cnt + 15'h1;
    end
  end

  for (genvar m = 0; m < `CMP_NMSG; m++) begin : g_tmr
    assign per_hit[m] = tick && (rate[m] != 14'h0) && (rcnt[m] >= rate[m] - 14'h1);
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        rcnt[m] <= 14'h0;
      end else if (!en[m] || rate[m] == 14'h0 || per_hit[m]) begin
        rcnt[m] <= 14'h0;
      end else if (tick) begin
        rcnt[m] <= rcnt[m] + 14'h1;
      end
    end
  end

  // a request or period hit arriving as the message starts is kept
  // gated by enable too: a hit taken in the very cycle of a disable must not start a frame
  assign start[0]  = (state == CMP_IDLE) && pend[0] && en[0];
  assign start[1]  = (state == CMP_IDLE) && !(pend[0] && en[0]) && pend[1] && en[1];
  assign next_pend = ((pend & ~start) | (REQ | per_hit)) & en;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pend <= '0;
    end else begin
      pend <= next_pend;
    end
  end

  // ********************************************
  // slot encoder
  // ********************************************
  logic [3:0]         ei;
  cmp_slot_t          ec;
  cmp_sig_t           es;
  logic               conn;
  logic signed [63:0] v;
  logic signed [63:0] q;
  logic [31:0]        code;
  logic [31:0]        vmax;
  logic [5:0]         w;
  logic [6:0]         sh;
  logic [63:0]        fmask;
  logic [63:0]        field;
  logic               disc;

  assign ei   = cur_m ? 4'(`CMP_NSLOT) + {1'b0, sc} : {1'b0, sc};
  assign ec   = slot[ei];
  assign conn = (ec.src < 4'(`CMP_NSRC));
  assign es   = SIG_IN[ec.src[2:0]];
  assign disc = (ec.kind == CMP_T_BIT1) || (ec.kind == CMP_T_BIT2) || (ec.kind == CMP_T_BIT4);

  always_comb begin
    w    = 6'd0;
    vmax = 32'h0;
    case (ec.kind)
      CMP_T_BIT1:  w = 6'd1;
      CMP_T_BIT2:  w = 6'd2;
      CMP_T_BIT4:  w = 6'd4;
      CMP_T_BYTE1: begin w = 6'd8;  vmax = 32'h000000fa; end
      CMP_T_BYTE2: begin w = 6'd16; vmax = 32'h0000faff; end
      CMP_T_BYTE4: begin w = 6'd32; vmax = 32'hfaffffff; end
      default:     w = 6'd0;
    endcase
  end

  // continuous scaling; the divide is wide but runs once per slot
  always_comb begin
    v = 64'(es.value);
    if (v > 64'(smax[ei])) begin
      v = 64'(smax[ei]);
    end
    if (v < 64'(smin[ei])) begin
      v = 64'(smin[ei]);
    end
    if (ec.inv) begin
      v = 64'(smax[ei]) + 64'(smin[ei]) - v;
    end
    q = (v - 64'(ofs[ei])) / 64'(res[ei]);
    if (q < 0) begin
      q = 64'sh0;
    end else if (q > $signed({32'h0, vmax})) begin
      q = $signed({32'h0, vmax});
    end
  end

  always_comb begin
    code = 32'h0;
    case (es.state)
      CMP_S_VALID: begin
        if (disc) begin
          code = {31'h0, (es.value != 32'sh0) ^ ec.inv};
        end else begin
          code = q[31:0];
        end
      end
      CMP_S_SPECIAL: begin
        case (ec.kind)
          CMP_T_BIT2:  code = 32'h3;
          CMP_T_BIT4:  code = 32'h2 + {28'h0, es.code[3:0]};
          CMP_T_BYTE1: code = 32'hfb + {30'h0, es.code[1:0]};
          CMP_T_BYTE2: code = 32'hfb00 + {23'h0, es.code[8:0]};
          CMP_T_BYTE4: code = 32'hfb000000 + {8'h0, es.code};
          default:     code = 32'h0;
        endcase
      end
      CMP_S_ERROR: begin
        case (ec.kind)
          CMP_T_BIT2:  code = 32'h2;
          CMP_T_BIT4:  code = 32'he;
          CMP_T_BYTE1: code = 32'hfe;
          CMP_T_BYTE2: code = {24'hfe, es.code[7:0]};
          CMP_T_BYTE4: code = {8'hfe, es.code};
          default:     code = 32'h0;
        endcase
      end
      default: begin
        case (ec.kind)
          CMP_T_BIT2:  code = 32'h3;
          CMP_T_BIT4:  code = 32'hf;
          CMP_T_BYTE1: code = 32'hff;
          CMP_T_BYTE2: code = 32'hff00;
          CMP_T_BYTE4: code = 32'hff000000;
          default:     code = 32'h0;
        endcase
      end
    endcase
  end

  // bits pushed past byte 8 are lost; discrete fields must not straddle
  assign sh    = {ec.bytepos[2:0] - 3'h1, 3'h0} + (disc ? {3'h0, ec.bitpos - 4'h1} : 7'h0);
  assign fmask = ((64'h1 << w) - 64'h1) << sh;
  assign field = ({32'h0, code} << sh) & fmask;

  // ********************************************
  // frame sequencer
  // ********************************************
  logic [7:0] ps;
  assign ps = (pgn[start[1]][15:8] < `CMP_PDU2_PF) ? `CMP_GLOBAL_DA : pgn[start[1]][7:0];

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= CMP_IDLE;
      cur_m <= 1'b0;
      sc    <= 3'h0;
    end else begin
      case (state)
        CMP_IDLE: begin
          if (|start) begin
            state <= CMP_PACK;
            cur_m <= start[1];
            sc    <= 3'h0;
          end
        end
        CMP_PACK: begin
          sc <= sc + 3'h1;
          if (sc == 3'(`CMP_NSLOT - 1)) begin
            state <= CMP_SEND;
          end
        end
        CMP_SEND: begin
          if (TX_READY) begin
            state <= CMP_IDLE;
          end
        end
        default: state <= CMP_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TX_FRAME <= '0;
    end else if (state == CMP_IDLE && |start) begin
      TX_FRAME.id   <= {`CMP_PRIO, pgn[start[1]][17:8], ps, SRC_ADDR};
      TX_FRAME.data <= `CMP_UNUSED;
    end else if (state == CMP_PACK && conn && ec.kind != CMP_T_UNDEF) begin
      TX_FRAME.data <= (TX_FRAME.data & ~fmask) | field;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sent[0] <= 16'h0;
      sent[1] <= 16'h0;
    end else if (state == CMP_SEND && TX_READY) begin
      sent[cur_m] <= sent[cur_m] + 16'h1;
    end
  end

  assign TX_VALID = (state == CMP_SEND);

endmodule // cmp_top

// ===== testbench/cmp_checker.sv
// concurrent checks on the ports of the message packer
`timescale 1ns/1ps
module cmp_checker (
  // clock and reset
  input wire logic                CORE_CLK,
  input wire logic                ARST_N,
  // wishbone
  input wire logic                WB_CYC_I,
  input wire logic                WB_STB_I,
  input wire logic                WB_WE_I,
  input wire logic                WB_ACK_O,
  // frame side
  input wire logic [7:0]          SRC_ADDR,
  input wire logic                TX_VALID,
  input wire logic                TX_READY,
  input wire cmp_pkg::cmp_frame_t TX_FRAME
);
  import cmp_pkg::*;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);
  // ****************************************
  // bus answers
  // ****************************************
  a_ack_follows_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  // ****************************************
  // frame offer
  // ****************************************
  a_frame_held: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_FRAME))
    else $error("frame dropped or changed while stalled");
  a_idle_after: assert property (TX_VALID && TX_READY |=> !TX_VALID)
    else $error("no idle cycle after a frame");
  a_pack_gap: assert property ($fell(TX_VALID) |-> !TX_VALID [*5])
    else $error("next frame offered too early");
  a_id_fixed: assert property (TX_VALID |-> TX_FRAME.id[28:26] == 3'h6
      && TX_FRAME.id[7:0] == SRC_ADDR)
    else $error("priority or source field wrong");
  a_pdu1_global: assert property (TX_VALID && TX_FRAME.id[23:16] < 8'hf0
      |-> TX_FRAME.id[15:8] == 8'hff)
    else $error("pdu1 frame not sent to global address");
  c_stall: cover property (TX_VALID && !TX_READY ##1 TX_VALID && TX_READY);
  c_write: cover property (WB_ACK_O && WB_WE_I);
  c_sent: cover property ($fell(TX_VALID));
endmodule // cmp_checker

bind cmp_top cmp_checker u_chk (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ACK_O(WB_ACK_O), .SRC_ADDR(SRC_ADDR), .TX_VALID(TX_VALID),
  .TX_READY(TX_READY), .TX_FRAME(TX_FRAME)
);

// ===== testbench/cmp_can_model.sv
// can controller stand-in that takes frames after a set stall
`timescale 1ns/1ps
module cmp_can_model (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // frame handshake
  input  wire logic                tx_valid,
  input  wire cmp_pkg::cmp_frame_t tx_frame,
  output logic                     tx_ready,
  // control and record
  input  wire logic [3:0]          stall,
  output logic [15:0]              got,
  output cmp_pkg::cmp_frame_t      last
);
  import cmp_pkg::*;
  logic [3:0] wait_c;
  // ready only while a frame is offered, so a stall really holds it back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
      wait_c   <= 4'h0;
      got      <= 16'h0;
      last     <= '0;
    end else if (tx_valid && tx_ready) begin
      got      <= got + 16'h1;
      last     <= tx_frame;
      tx_ready <= 1'b0;
      wait_c   <= 4'h0;
    end else if (tx_valid) begin
      if (wait_c >= stall) tx_ready <= 1'b1;
      else wait_c <= wait_c + 4'h1;
    end
  end
endmodule // cmp_can_model

// ===== testbench/test_can_output_message_packer.sv
// self-checking bench for the can output message packer
`timescale 1ns/1ps
module test_can_output_message_packer;
  import cmp_pkg::*;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic              we = 1'b0;
  logic [9:0]        adr = 10'h0;
  logic [31:0]       wdat = 32'h0;
  logic [31:0]       rdat;
  logic [31:0]       dat_o;
  logic              ack;
  logic [1:0]        req = 2'h0;
  cmp_sig_t [7:0]    sig = '0;
  logic              tx_valid;
  logic              tx_ready;
  cmp_frame_t        frame;
  cmp_frame_t        last;
  logic [15:0]       got;
  logic [15:0]       c0;
  logic [3:0]        stall = 4'h0;
  logic [9:0]        b;
  int                errors = 0;
  int                comparisons = 0;

  always #25 clk = ~clk;

  cmp_top #(.MS_CYCLES(20)) DUT (
    .CORE_CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .SIG_IN(sig), .REQ(req), .SRC_ADDR(8'h2a), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .TX_FRAME(frame)
  );
  cmp_can_model u_can (
    .clk(clk), .rst_n(arst_n), .tx_valid(tx_valid), .tx_frame(frame),
    .tx_ready(tx_ready), .stall(stall), .got(got), .last(last)
  );
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string name, input logic [63:0] e, input logic [63:0] a);
    comparisons++;
    if (a !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, e, a);
    end
  endtask
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n >= 50) chk("bus answer", 64'h1, 64'h0);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e, input string name);
    wb(1'b0, a, 32'h0);
    chk(name, {32'h0, e}, {32'h0, rdat});
  endtask
  task automatic pulse(input int m);
    @(posedge clk);
    req[m] <= 1'b1;
    @(posedge clk);
    req[m] <= 1'b0;
  endtask
  task automatic wait_frame(input logic [15:0] t);
    int n = 0;
    while (got !== t && n < 300) begin
      n++;
      @(posedge clk);
    end
    chk("frame count", {48'h0, t}, {48'h0, got});
  endtask
  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************
  // watchdog: the whole run needs some 900 cycles
  // ****************************************
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      b = 10'(m * 256);
      rd(b + 10'h4, 32'h0ff01 + m, "pgn");
      rd(b, 32'h0, "ctrl");
      rd(b + 10'h8, 32'h0, "rate");
      for (int s = 0; s < 5; s++) begin
        b = 10'(m * 256 + 32 + s * 32);
        rd(b, 32'h11f0, "slot cfg");
        rd(b + 10'h4, 32'h1, "res");
        rd(b + 10'h8, 32'h0, "offset");
        rd(b + 10'hc, 32'h1, "max");
        rd(b + 10'h10, 32'h0, "min");
      end
    end
    rd(10'h200, 32'h0, "unmapped");
    wb(1'b1, 10'h24, 32'h0);
    rd(10'h24, 32'h1, "zero res");
    wb(1'b1, 10'h30, 32'h5);
    rd(10'h30, 32'h0, "min over max");
    wb(1'b1, 10'h08, 32'd10001);
    rd(10'h08, 32'h0, "rate over");
    wb(1'b1, 10'h08, 32'd10000);
    rd(10'h08, 32'd10000, "rate top");
    wb(1'b1, 10'h08, 32'h0);
    wb(1'b1, 10'h20, 32'h19f1);
    rd(10'h20, 32'h11f0, "byte pos 9");
    wb(1'b1, 10'h20, 32'h11f7);
    rd(10'h20, 32'h11f0, "type 7");
    // disabled message ignores requests
    pulse(0);
    repeat (20) @(posedge clk);
    chk("disabled", 64'h0, {48'h0, got});
    wb(1'b1, 10'h20, 32'h3102);
    wb(1'b1, 10'h40, 32'h1119);
    wb(1'b1, 10'h60, 32'h1225);
    wb(1'b1, 10'h64, 32'h2);
    wb(1'b1, 10'h68, 32'ha);
    wb(1'b1, 10'h6c, 32'h3e8);
    wb(1'b1, 10'h80, 32'h1434);
    wb(1'b1, 10'ha0, 32'h1545);
    sig[0] <= '{CMP_S_VALID, 24'h0, 32'sh3};
    sig[1] <= '{CMP_S_VALID, 24'h0, 32'sh5};
    sig[2] <= '{CMP_S_VALID, 24'h0, 32'sh1f4};
    sig[3] <= '{CMP_S_ERROR, 24'h0, 32'sh0};
    sig[4] <= '{CMP_S_ERROR, 24'h1, 32'sh0};
    stall <= 4'h3;
    wb(1'b1, 10'h00, 32'h1);
    pulse(0);
    wait_frame(16'h1);
    chk("id", {35'h0, 3'h6, 10'h0ff, 8'h01, 8'h2a}, {35'h0, last.id});
    chk("data", 64'hfffffe01fe00f5f6, last.data);
    // above max: clamped to max before scaling
    sig[2] <= '{CMP_S_VALID, 24'h0, 32'sd100000};
    pulse(0);
    wait_frame(16'h2);
    chk("clamp", 64'hfffffe01fe01eff6, last.data);
    rd(10'h0c, 32'h2, "sent");
    // special codes on 4-bit and 2-byte slots, inverted continuous slot
    wb(1'b1, 10'h60, 32'h122d);
    wb(1'b1, 10'h80, 32'h5433);
    sig[2] <= '{CMP_S_VALID, 24'h0, 32'sd100};
    sig[3] <= '{CMP_S_SPECIAL, 24'h3, 32'sh0};
    sig[4] <= '{CMP_S_SPECIAL, 24'h10, 32'sh0};
    pulse(0);
    wait_frame(16'h3);
    chk("special", 64'hfffffb105f01bdf6, last.data);
    // periodic pdu1 message: 2 ms of 20 cycles, 40 cycles apart
    wb(1'b1, 10'h104, 32'h0ef00);
    wb(1'b1, 10'h108, 32'h2);
    stall <= 4'h0;
    c0 = got;
    wb(1'b1, 10'h100, 32'h1);
    repeat (400) @(posedge clk);
    chk("periodic", 64'h1, {63'h0, (got - c0) >= 9 && (got - c0) <= 11});
    chk("global", {35'h0, 3'h6, 10'h0ef, 8'hff, 8'h2a}, {35'h0, last.id});
    chk("empty slots", 64'hffffffffffffffff, last.data);
    rd(10'h0c, 32'h3, "request only");
    wb(1'b1, 10'h100, 32'h0);
    // a frame already in flight at the disable may still finish
    repeat (12) @(posedge clk);
    c0 = got;
    repeat (100) @(posedge clk);
    chk("stopped", {48'h0, c0}, {48'h0, got});
    test_done;
  end
endmodule // test_can_output_message_packer
